// ==== hdl/cksq_top.sv ====
// command sequencer for key, vector, start and stop commands
`timescale 1ns/1ps
`include "cksq_cfg.svh"
module cksq_top (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cmdWr,
  input wire logic [7:0] cmdByte,
  input wire logic inWr,
  input wire logic [7:0] inByte,
  input wire logic secWr,
  input wire logic [7:0] secByte,
  input wire logic outRd,
  output logic [7:0] outByte,
  output logic outReady,
  input wire logic auxStbN,
  input wire logic [7:0] auxData,
  input wire logic runHaltPin,
  input wire logic directionPin,
  input wire logic pinMode,
  input wire logic inputOnSecond,
  input wire logic cfbMode,
  input wire logic modeLoad,
  input wire logic modeDir,
  output logic coreStart,
  output logic [1:0] coreKey,
  output logic coreEncrypt,
  output logic [63:0] coreData,
  output logic coreAbort,
  input wire logic coreDone,
  input wire logic [63:0] coreResult,
  output logic keyWr,
  output logic keyToEnc,
  output logic [7:0] keyByte,
  output logic keyParErr,
  output logic cmdPendingBit,
  output logic cipherBusyBit,
  output logic runHaltBit,
  output logic directionModeBit,
  output logic hostPortFlagN,
  output logic secondPortFlagN,
  output logic busyPinN
);
  cksq_pkg::cksq_state_t state, next_state;
  logic [7:0] curCmd, next_cmd;
  logic [3:0] cnt, next_cnt, outCnt, next_outCnt;
  logic [63:0] inReg, next_in, outReg, next_out, next_core, memRd;
  logic [1:0] next_key;
  logic next_enc, next_run, next_dir, next_pend, next_busy;
  logic cStart, cAbort, kWr, mWe, runPrev, stbPrev;
  logic [10:0] pinSync;
  //////////////////////////////////////////////////////////////////////
  // pin synchronisers and the vector store
  cksq_sync #(.W(11)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    // strobe inverted so its idle level matches the synchroniser reset
    .d({~auxStbN, auxData, runHaltPin, directionPin}),
    .q(pinSync)
  );
  cksq_vec_mem u_mem (
    .mclk(mclk),
    .rst_n(rst_n),
    .we(mWe),
    .waddr(curCmd[0]),
    .wdata(state == cksq_pkg::ST_GATHER ? next_in : coreResult),
    .raddr(curCmd[0]),
    .rdata(memRd)
  );
  //////////////////////////////////////////////////////////////////////
  // decode
  wire stbS = pinSync[10];
  wire [7:0] auxS = pinSync[9:2];
  wire runS = pinSync[1];
  wire dirS = pinSync[0];
  wire auxTake = ~stbS & stbPrev;
  wire pinStart = pinMode & runS & ~runPrev;
  wire pinStop = pinMode & ~runS & runPrev;
  wire pinEv = pinStart | pinStop;
  wire c0 = curCmd[0];
  wire kAux = curCmd == `CKSQ_CMD_EKEY_AUX || curCmd == `CKSQ_CMD_DKEY_AUX;
  wire kHost = curCmd == `CKSQ_CMD_EKEY_HOST || curCmd == `CKSQ_CMD_DKEY_HOST;
  wire vClr = curCmd == `CKSQ_CMD_EVEC_CLR || curCmd == `CKSQ_CMD_DVEC_CLR;
  wire vEnc = curCmd == `CKSQ_CMD_EVEC_ENC || curCmd == `CKSQ_CMD_DVEC_ENC;
  wire rEnc = curCmd == `CKSQ_CMD_RD_EVEC_ENC
    || curCmd == `CKSQ_CMD_RD_DVEC_ENC;
  wire mEnc = curCmd == `CKSQ_CMD_MK_ENCRYPT;
  wire nLoad = cmdByte == `CKSQ_CMD_EKEY_AUX
    || cmdByte == `CKSQ_CMD_DKEY_AUX || cmdByte == `CKSQ_CMD_EKEY_HOST
    || cmdByte == `CKSQ_CMD_DKEY_HOST || cmdByte == `CKSQ_CMD_EVEC_CLR
    || cmdByte == `CKSQ_CMD_DVEC_CLR || cmdByte == `CKSQ_CMD_EVEC_ENC
    || cmdByte == `CKSQ_CMD_DVEC_ENC || cmdByte == `CKSQ_CMD_MK_ENCRYPT;
  wire nRead = cmdByte == `CKSQ_CMD_RD_EVEC_CLR
    || cmdByte == `CKSQ_CMD_RD_DVEC_CLR || cmdByte == `CKSQ_CMD_RD_EVEC_ENC
    || cmdByte == `CKSQ_CMD_RD_DVEC_ENC;
  wire cStartCmd = cmdByte == `CKSQ_CMD_START_ENC
    || cmdByte == `CKSQ_CMD_START_DEC || cmdByte == `CKSQ_CMD_START;
  wire startEv = (cmdWr & cStartCmd) | pinStart;
  wire stopEv = (cmdWr & cmdByte == `CKSQ_CMD_STOP) | pinStop;
  wire running = state == cksq_pkg::ST_RUN && runHaltBit;
  wire byteTake = state == cksq_pkg::ST_GATHER
    ? (kAux ? auxTake : inWr)
    : running && (inputOnSecond ? secWr : inWr);
  wire [7:0] byteVal = state == cksq_pkg::ST_GATHER
    ? (kAux ? auxS : inByte)
    : (inputOnSecond ? secByte : inByte);
  wire [3:0] need = runHaltBit && cfbMode ? `CKSQ_CFB_BYTES
    : `CKSQ_BLOCK_BYTES;
  wire full = byteTake && cnt == need - 4'h1;
  wire readTake = outRd && outCnt != 4'h0;
  wire nextAccept = next_state == cksq_pkg::ST_GATHER
    || next_state == cksq_pkg::ST_RUN;
  wire nextOnSec = next_state == cksq_pkg::ST_RUN ? inputOnSecond
    : (next_cmd == `CKSQ_CMD_EKEY_AUX || next_cmd == `CKSQ_CMD_DKEY_AUX);
  //////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_state = state;
    next_cmd = curCmd;
    next_cnt = cnt;
    next_in = inReg;
    next_out = outReg;
    next_outCnt = outCnt;
    next_core = coreData;
    next_key = coreKey;
    next_enc = coreEncrypt;
    next_run = runHaltBit;
    next_dir = modeLoad ? modeDir : directionModeBit;
    cStart = 1'b0;
    cAbort = 1'b0;
    kWr = 1'b0;
    mWe = 1'b0;
    if (byteTake) begin
      next_in = {inReg[55:0], byteVal};
      next_cnt = cnt + 4'h1;
    end
    if (readTake) begin
      next_out = {outReg[55:0], 8'h00};
      next_outCnt = outCnt - 4'h1;
    end
    case (state)
      cksq_pkg::ST_GATHER: begin
        if (full) begin
          next_cnt = 4'h0;
          if (vClr) begin
            mWe = 1'b1;
            next_state = cksq_pkg::ST_IDLE;
          end else begin
            cStart = 1'b1;
            next_core = next_in;
            next_key = vEnc ? cksq_pkg::KEY_DEC : cksq_pkg::KEY_MASTER;
            next_enc = mEnc;
            next_state = cksq_pkg::ST_CORE;
          end
        end
      end
      cksq_pkg::ST_IVRD: begin
        next_cnt = cnt + 4'h1;
        if (rEnc && cnt == `CKSQ_MEM_LAT) begin
          cStart = 1'b1;
          next_core = memRd;
          next_key = cksq_pkg::KEY_ENC;
          next_enc = 1'b1;
          next_state = cksq_pkg::ST_CORE;
        end else if (!rEnc && cnt == `CKSQ_IVRD_CLKS) begin
          next_out = memRd;
          next_outCnt = `CKSQ_BLOCK_BYTES;
          next_state = cksq_pkg::ST_OUTQ;
        end
      end
      cksq_pkg::ST_CORE: begin
        if (coreDone) begin
          next_cnt = 4'h0;
          next_out = coreResult;
          if (kAux || kHost) begin
            next_state = cksq_pkg::ST_KEYOUT;
          end else if (vEnc) begin
            mWe = 1'b1;
            next_state = cksq_pkg::ST_IDLE;
          end else begin
            next_outCnt = runHaltBit ? need : `CKSQ_BLOCK_BYTES;
            next_state = runHaltBit ? cksq_pkg::ST_RUN
              : cksq_pkg::ST_OUTQ;
          end
        end
      end
      cksq_pkg::ST_KEYOUT: begin
        kWr = 1'b1;
        next_out = {outReg[55:0], 8'h00};
        next_cnt = cnt + 4'h1;
        if (cnt == `CKSQ_BLOCK_BYTES - 4'h1) begin
          next_state = cksq_pkg::ST_IDLE;
        end
      end
      cksq_pkg::ST_OUTQ: begin
        if (readTake && outCnt == 4'h1) begin
          next_state = cksq_pkg::ST_IDLE;
        end
      end
      cksq_pkg::ST_RUN: begin
        if (full) begin
          cStart = 1'b1;
          next_cnt = 4'h0;
          next_core = next_in;
          next_key = directionModeBit ? cksq_pkg::KEY_ENC
            : cksq_pkg::KEY_DEC;
          next_enc = directionModeBit;
          next_state = cksq_pkg::ST_CORE;
        end
      end
      default: begin
        next_state = cksq_pkg::ST_IDLE;
      end
    endcase
    if (cmdWr || pinEv) begin
      cAbort = state == cksq_pkg::ST_CORE;
      next_cnt = 4'h0;
      next_run = 1'b0;
      next_state = cksq_pkg::ST_IDLE;
      if (!(stopEv && !cfbMode)) begin
        next_outCnt = 4'h0;
      end
      next_cmd = cmdWr ? cmdByte
        : (pinStart ? `CKSQ_CMD_START : `CKSQ_CMD_STOP);
      if (cmdWr && nLoad) begin
        next_state = cksq_pkg::ST_GATHER;
      end
      if (cmdWr && nRead) begin
        next_cnt = 4'h1;
        next_state = cksq_pkg::ST_IVRD;
      end
      if (startEv) begin
        next_run = 1'b1;
        next_state = cksq_pkg::ST_RUN;
        if (pinStart) begin
          next_dir = dirS;
        end else if (cmdByte != `CKSQ_CMD_START) begin
          next_dir = cmdByte == `CKSQ_CMD_START_ENC;
        end
      end
      if (stopEv) begin
        next_run = 1'b0;
        next_state = cksq_pkg::ST_IDLE;
      end
      if (cmdWr && cmdByte == `CKSQ_CMD_RESET) begin
        next_dir = `CKSQ_DIR_RESET;
      end
    end
    next_pend = next_state == cksq_pkg::ST_GATHER
      || next_state == cksq_pkg::ST_IVRD
      || next_state == cksq_pkg::ST_KEYOUT
      || next_state == cksq_pkg::ST_OUTQ
      || (next_state == cksq_pkg::ST_CORE && !next_run);
    next_busy = next_state == cksq_pkg::ST_CORE
      && !(next_cmd == `CKSQ_CMD_EVEC_ENC
      || next_cmd == `CKSQ_CMD_DVEC_ENC);
  end
  //////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= cksq_pkg::ST_IDLE;
      curCmd <= 8'h00;
      cnt <= 4'h0;
      outCnt <= 4'h0;
      inReg <= 64'h0;
      outReg <= 64'h0;
      coreData <= 64'h0;
      coreKey <= cksq_pkg::KEY_MASTER;
      coreEncrypt <= 1'b0;
      runHaltBit <= 1'b0;
      directionModeBit <= `CKSQ_DIR_RESET;
      cmdPendingBit <= 1'b0;
      cipherBusyBit <= 1'b0;
      busyPinN <= 1'b1;
      hostPortFlagN <= 1'b1;
      secondPortFlagN <= 1'b1;
      outReady <= 1'b0;
      coreStart <= 1'b0;
      coreAbort <= 1'b0;
    end else begin
      state <= next_state;
      curCmd <= next_cmd;
      cnt <= next_cnt;
      outCnt <= next_outCnt;
      inReg <= next_in;
      outReg <= next_out;
      coreData <= next_core;
      coreKey <= next_key;
      coreEncrypt <= next_enc;
      runHaltBit <= next_run;
      directionModeBit <= next_dir;
      cmdPendingBit <= next_pend;
      cipherBusyBit <= next_busy;
      busyPinN <= ~next_busy;
      hostPortFlagN <= ~(nextAccept && !nextOnSec);
      secondPortFlagN <= ~(nextAccept && nextOnSec);
      outReady <= next_outCnt != 4'h0;
      coreStart <= cStart;
      coreAbort <= cAbort;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      runPrev <= 1'b0;
      stbPrev <= 1'b0;
      keyWr <= 1'b0;
      keyToEnc <= 1'b0;
      keyByte <= 8'h00;
      keyParErr <= 1'b0;
    end else begin
      runPrev <= runS;
      stbPrev <= stbS;
      keyWr <= kWr;
      keyToEnc <= c0;
      if (kWr) begin
        keyByte <= outReg[63:56];
        keyParErr <= ~^outReg[63:56];
      end
    end
  end
  assign outByte = outReg[63:56];
  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire quiet = !cmdWr && !pinEv;
  sequence sRdClr;
    cmdWr && !pinEv && (cmdByte == `CKSQ_CMD_RD_EVEC_CLR
      || cmdByte == `CKSQ_CMD_RD_DVEC_CLR);
  endsequence
  a_ivrd_early: assert property (sRdClr |=> !outReady [*6])
    else $error("vector byte offered too early");
  a_ivrd_ready: assert property (sRdClr ##1 quiet [*6] |=> outReady)
    else $error("vector byte not offered in time");
  a_keyld_busy: assert property (state == cksq_pkg::ST_CORE
    && (kAux || kHost) |-> cmdPendingBit && cipherBusyBit)
    else $error("key load flags wrong");
  a_ivenc_flags: assert property (state == cksq_pkg::ST_CORE && vEnc
    |-> cmdPendingBit && !cipherBusyBit)
    else $error("vector decrypt flags wrong");
  a_keyout_write: assert property (state == cksq_pkg::ST_KEYOUT
    && quiet |=> keyWr && keyByte == $past(outReg[63:56]))
    else $error("key byte not written");
  a_start_enc: assert property (cmdWr && !pinEv
    && cmdByte == `CKSQ_CMD_START_ENC && !inputOnSecond
    |=> runHaltBit && directionModeBit && !hostPortFlagN)
    else $error("start encryption failed");
  a_stop_flags: assert property (stopEv
    |=> !runHaltBit && hostPortFlagN && secondPortFlagN)
    else $error("stop left run state");
  a_stop_abort: assert property (stopEv && state == cksq_pkg::ST_CORE
    |=> coreAbort && !cipherBusyBit)
    else $error("stop did not abort");
  a_mk_busy: assert property (state == cksq_pkg::ST_GATHER && mEnc
    && full && quiet |=> coreStart && cipherBusyBit)
    else $error("encrypt not started");
  a_last_read: assert property (state == cksq_pkg::ST_OUTQ && readTake
    && outCnt == 4'h1 && quiet |=> !cmdPendingBit)
    else $error("pending kept after last byte");
endmodule

// ==== hdl/cksq_cfg.svh ====
// command codes, counts and reset values of the key and vector sequencer
`ifndef CKSQ_CFG_SVH
`define CKSQ_CFG_SVH
`define CKSQ_CMD_EKEY_AUX 8'hB1
`define CKSQ_CMD_DKEY_AUX 8'hB2
`define CKSQ_CMD_EKEY_HOST 8'h31
`define CKSQ_CMD_DKEY_HOST 8'h32
`define CKSQ_CMD_EVEC_CLR 8'h85
`define CKSQ_CMD_DVEC_CLR 8'h84
`define CKSQ_CMD_EVEC_ENC 8'hA5
`define CKSQ_CMD_DVEC_ENC 8'hA4
`define CKSQ_CMD_RD_EVEC_CLR 8'h8D
`define CKSQ_CMD_RD_DVEC_CLR 8'h8C
`define CKSQ_CMD_RD_EVEC_ENC 8'hA9
`define CKSQ_CMD_RD_DVEC_ENC 8'hA8
`define CKSQ_CMD_MK_ENCRYPT 8'h39
`define CKSQ_CMD_START_ENC 8'h41
`define CKSQ_CMD_START_DEC 8'h40
`define CKSQ_CMD_START 8'hC0
`define CKSQ_CMD_STOP 8'hE0
`define CKSQ_CMD_RESET 8'h00
`define CKSQ_BLOCK_BYTES 4'h8
`define CKSQ_CFB_BYTES 4'h1
`define CKSQ_IVRD_CLKS 4'h6
`define CKSQ_MEM_LAT 4'h2
`define CKSQ_DIR_RESET 1'b1
`define CKSQ_ENC_VECTOR 1'b1
`endif

// ==== hdl/cksq_pkg.sv ====
// types of the key and vector sequencer
package cksq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_GATHER = 3'b001,
    ST_CORE = 3'b010,
    ST_KEYOUT = 3'b011,
    ST_IVRD = 3'b100,
    ST_OUTQ = 3'b101,
    ST_RUN = 3'b110
  } cksq_state_t;
  typedef enum logic [1:0] {
    KEY_MASTER = 2'b00,
    KEY_ENC = 2'b01,
    KEY_DEC = 2'b10
  } cksq_key_t;
endpackage

// ==== hdl/cksq_sync.sv ====
// two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module cksq_sync #(parameter int W = 1) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// ==== hdl/cksq_vec_mem.sv ====
// two-entry store for the encrypt and decrypt vectors, registered read
`timescale 1ns/1ps
module cksq_vec_mem (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic waddr,
  input wire logic [63:0] wdata,
  input wire logic raddr,
  output logic [63:0] rdata
);
  logic [63:0] mem [0:1];
  always_ff @(posedge mclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 64'h0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule

// ==== verif/cksq_core_model.sv ====
// cipher core stand-in answering start pulses after a short or long delay
`timescale 1ns/1ps
module cksq_core_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic coreStart,
  input wire logic [1:0] coreKey,
  input wire logic coreEncrypt,
  input wire logic [63:0] coreData,
  input wire logic coreAbort,
  output logic coreDone,
  output logic [63:0] coreResult
);
  logic [7:0] cnt;
  logic [63:0] res;
  // result line toggles outside the done pulse, so stale data is inverted on alternate cycles
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 8'h00;
      coreDone <= 1'b0;
      coreResult <= 64'h0;
      res <= 64'h0;
    end else begin
      coreDone <= 1'b0;
      coreResult <= ~coreResult;
      if (coreAbort) begin
        cnt <= 8'h00;
      end else if (coreStart) begin
        cnt <= slow ? 8'h28 : 8'h03;
        res <= coreData ^ {8{coreKey, coreEncrypt, 5'h15}};
      end else if (cnt == 8'h01) begin
        cnt <= 8'h00;
        coreDone <= 1'b1;
        coreResult <= res;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end
    end
  end
endmodule

// ==== verif/cksq_top_tb.sv ====
// self-checking bench for the key and vector sequencer
`timescale 1ns/1ps
module cksq_top_tb;
  logic mclk, rst_n, cmdWr, inWr, secWr, outRd, auxStbN, slow;
  logic runHaltPin, directionPin, pinMode, inputOnSecond, cfbMode;
  logic modeLoad, modeDir, coreDone, coreStart, coreEncrypt, coreAbort;
  logic keyWr, keyToEnc, keyParErr, outReady, cmdPendingBit;
  logic cipherBusyBit, runHaltBit, directionModeBit, hostPortFlagN;
  logic secondPortFlagN, busyPinN;
  logic [7:0] cmdByte, inByte, secByte, auxData, outByte, keyByte;
  logic [1:0] coreKey;
  logic [63:0] coreData, coreResult, v;
  logic [63:0] iv [2];
  logic [7:0] outQ [$];
  logic [9:0] keyQ [$];
  int err_total, n_compared, cyc, nAbort, na;
  cksq_top DUT (.*);
  cksq_core_model core (.*);
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [63:0] fx(logic [63:0] d, logic [1:0] k,
                                     logic e);
    return d ^ {8{k, e, 5'h15}};
  endfunction
  task automatic chk(string n, logic [63:0] e, logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic test_done;
    if (err_total == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic cmd(logic [7:0] b);
    cmdWr = 1'b1;
    cmdByte = b;
    tick(1);
    cmdWr = 1'b0;
  endtask
  task automatic wrN(logic [63:0] d, int n);
    for (int i = 7; i > 7 - n; i--) begin
      inWr = 1'b1;
      inByte = d[i*8+:8];
      tick(1);
    end
    inWr = 1'b0;
  endtask
  task automatic aux8(logic [63:0] d);
    for (int i = 7; i >= 0; i--) begin
      auxData = d[i*8+:8];
      auxStbN = 1'b0;
      tick(3);
      auxStbN = 1'b1;
      tick(4);
    end
  endtask
  task automatic rd8(logic [63:0] d);
    int k;
    k = 0;
    for (int i = 7; i >= 0; i--) outQ.push_back(d[i*8+:8]);
    while (outReady !== 1'b1 && k < 200) begin
      tick(1);
      k++;
    end
    chk("outReady", 1, outReady);
    outRd = 1'b1;
    tick(8);
    outRd = 1'b0;
    tick(2);
  endtask
  task automatic modeSet(logic d);
    modeDir = d;
    modeLoad = 1'b1;
    tick(1);
    modeLoad = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (outRd && outReady) begin
      if (outQ.size() == 0) chk("outExtra", 0, 1);
      else chk("outByte", outQ.pop_front(), outByte);
    end
    if (keyWr) begin
      if (keyQ.size() == 0) chk("keyExtra", 0, 1);
      else chk("key", keyQ.pop_front(),
               {keyToEnc, keyParErr, keyByte});
    end
    if (coreAbort) nAbort++;
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    {cmdWr, inWr, secWr, outRd, runHaltPin, directionPin} = 6'h00;
    {pinMode, inputOnSecond, cfbMode, modeLoad, modeDir, slow} = 6'h00;
    {cmdByte, inByte, secByte, auxData} = 32'h0;
    auxStbN = 1'b1;
    void'($urandom(39));
    repeat (2) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    chk("rstFlags", 7'h0F, {cmdPendingBit, cipherBusyBit, runHaltBit,
        directionModeBit, hostPortFlagN, secondPortFlagN, busyPinN});
    for (int i = 0; i < 2; i++) begin
      iv[i] = {$urandom, $urandom};
      cmd(i ? 8'h84 : 8'h85);
      chk("pendLd", 1, cmdPendingBit);
      wrN(iv[i], 8);
      tick(3);
      chk("pendLdEnd", 0, cmdPendingBit);
      cmd(i ? 8'h8C : 8'h8D);
      tick(5);
      chk("rdyEarly", 0, outReady);
      tick(1);
      chk("rdyAt6", 1, outReady);
      chk("pendRd", 1, cmdPendingBit);
      rd8(iv[i]);
      chk("pendRdEnd", 0, cmdPendingBit);
      slow = 1'b1;
      cmd(i ? 8'hA8 : 8'hA9);
      tick(8);
      chk("busyEncRd", 2'b10, {cipherBusyBit, busyPinN});
      chk("pendEncRd", 1, cmdPendingBit);
      rd8(fx(iv[i], 2'b01, 1'b1));
      chk("pendEncRdEnd", 0, cmdPendingBit);
      slow = 1'b0;
      v = {$urandom, $urandom};
      cmd(i ? 8'hA4 : 8'hA5);
      wrN(v, 8);
      chk("encLdFlags", 2'b01, {cipherBusyBit, cmdPendingBit});
      tick(12);
      chk("encLdEnd", 0, cmdPendingBit);
      cmd(i ? 8'h8C : 8'h8D);
      rd8(fx(v, 2'b10, 1'b0));
    end
    v = {$urandom, $urandom};
    cmd(8'h39);
    chk("mkPend", 1, cmdPendingBit);
    wrN(v, 8);
    chk("mkBusy", 1, cipherBusyBit);
    rd8(fx(v, 2'b00, 1'b1));
    chk("mkPendEnd", 0, cmdPendingBit);
    slow = 1'b1;
    for (int i = 0; i < 4; i++) begin
      byte unsigned c;
      logic [63:0] r;
      c = (i < 2) ? 8'h31 + i : 8'hB1 + i - 2;
      v = {$urandom, $urandom};
      r = fx(v, 2'b00, 1'b0);
      for (int j = 7; j >= 0; j--)
        keyQ.push_back({~c[1], ~^r[j*8+:8], r[j*8+:8]});
      cmd(c);
      if (i < 2) wrN(v, 8);
      else aux8(v);
      tick(3);
      chk("keyBusy", 2'b11, {cipherBusyBit, cmdPendingBit});
      tick(60);
      chk("keyDone", 0, {keyQ.size(), cmdPendingBit});
    end
    for (int i = 0; i < 3; i++) begin
      modeSet(i != 0);
      inputOnSecond = (i == 2);
      cmd(i == 0 ? 8'h41 : (i == 1 ? 8'h40 : 8'hC0));
      chk("runSet", 1, runHaltBit);
      chk("dirSet", i != 1, directionModeBit);
      chk("inFlag", 0, i == 2 ? secondPortFlagN : hostPortFlagN);
      cmd(8'hE0);
      chk("stop", 3'b011, {runHaltBit, hostPortFlagN, secondPortFlagN});
    end
    inputOnSecond = 1'b0;
    cmd(8'h41);
    wrN(v, 8);
    chk("runBusy", 1, cipherBusyBit);
    na = nAbort;
    cmd(8'hE0);
    tick(2);
    chk("abort", 1, nAbort - na);
    chk("abortBusy", 0, cipherBusyBit);
    wrN(v, 8);
    tick(2);
    chk("inBlocked", 0, cipherBusyBit);
    modeSet(1'b0);
    cmd(8'h85);
    wrN(v, 3);
    cmd(8'hC0);
    chk("abortNew", 3'b010,
        {cmdPendingBit, runHaltBit, directionModeBit});
    cmd(8'h00);
    chk("swReset", 2'b01, {runHaltBit, directionModeBit});
    pinMode = 1'b1;
    for (int i = 0; i < 2; i++) begin
      directionPin = !i;
      tick(1);
      runHaltPin = 1'b1;
      tick(5);
      chk("pinStart", {1'b1, !i}, {runHaltBit, directionModeBit});
      runHaltPin = 1'b0;
      tick(5);
      chk("pinStop", 2'b01, {runHaltBit, hostPortFlagN});
    end
    pinMode = 1'b0;
    slow = 1'b0;
    for (int i = 0; i < 2; i++) begin
      cfbMode = i;
      v = {$urandom, $urandom};
      cmd(8'h85);
      wrN(v, 8);
      cmd(8'h41);
      wrN(v, i ? 1 : 8);
      v = fx(i ? {v[55:0], v[63:56]} : v, 2'b01, 1'b1);
      tick(8);
      chk("runOut", 1, outReady);
      if (i) begin
        outQ.push_back(v[63:56]);
        outRd = 1'b1;
        tick(1);
        outRd = 1'b0;
        chk("cfbOne", 0, outReady);
      end
      cmd(8'hE0);
      if (!i) rd8(v);
    end
    cfbMode = 1'b0;
    chk("queues", 0, outQ.size() + keyQ.size());
    test_done();
  end
endmodule
